/* File: staged_watchdog_timer.sv */
// three four-stage watchdogs with write protection and boot arming
`timescale 1ns/1ps
`default_nettype none
module staged_watchdog_timer #(
    parameter logic [31:0] BOOT_PROT_CYC = staged_watchdog_pkg::BOOT_PROT_CYC
) (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         nrst_i,
    // configuration port, one slot per watchdog
    input  wire logic [2:0]                   cfg_we_i,
    input  wire staged_watchdog_pkg::wdt_cfg_t [2:0] cfg_i,
    input  wire logic [2:0]                   wprot_i,
    input  wire logic [2:0]                   feed_i,
    // boot status pins
    input  wire logic                         flash_boot_i,
    input  wire logic                         boot_done_i,
    // events and status
    output wire staged_watchdog_pkg::wdt_evt_t [2:0] evt_o,
    output wire logic [2:0][1:0]              stage_o,
    output wire logic [2:0][31:0]             count_o
);
    logic       rst_s1_q;
    logic       rst_n;
    logic [1:0] boot_s1_q;
    logic [1:0] boot_s2_q;
    wire        boot_active = boot_s2_q[0];
    wire        boot_done   = boot_s2_q[1];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // boot pins come from outside the clock domain
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            boot_s1_q <= 2'h0;
            boot_s2_q <= 2'h0;
        end else begin
            boot_s1_q <= {boot_done_i, flash_boot_i};
            boot_s2_q <= boot_s1_q;
        end
    end

    // boot protection: a long action-reset stage armed by hardware
    logic [31:0] boot_cnt_q;
    logic        boot_armed_q;
    logic        boot_fire_q;
    wire         boot_expire = boot_armed_q && (boot_cnt_q >= BOOT_PROT_CYC);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt_q   <= staged_watchdog_pkg::CNT_RST;
            boot_armed_q <= 1'b0;
            boot_fire_q  <= 1'b0;
        end else begin
            boot_fire_q <= boot_expire;
            if (boot_done || boot_expire) begin
                boot_armed_q <= 1'b0;
                boot_cnt_q   <= staged_watchdog_pkg::CNT_RST;
            end else if (boot_active) begin
                boot_armed_q <= 1'b1;
                boot_cnt_q   <= boot_cnt_q + 32'h0000_0001;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_wdt
            staged_watchdog_pkg::wdt_cfg_t cfg_q;
            logic [31:0] cnt_q;
            logic [1:0]  stg_q;
            staged_watchdog_pkg::wdt_evt_t evt_q;
            localparam bit IS_RTC = (g == staged_watchdog_pkg::IDX_RTC);
            localparam bit BOOT_ARM = (g != staged_watchdog_pkg::IDX_TG1);
            // write accepted only while unprotected
            wire cfg_take = cfg_we_i[g] && !wprot_i[g];
            wire running  = cfg_q.en || (BOOT_ARM && boot_armed_q);
            wire stg_on   = cfg_q.stage_en[stg_q];
            wire expire   = running && stg_on &&
                            (cnt_q >= cfg_q.timeout[stg_q]);
            // disabled stages are skipped without counting
            wire skip     = running && !stg_on;
            staged_watchdog_pkg::wdt_action_t act;
            assign act = cfg_q.action[stg_q];
            wire hit = expire && !feed_i[g];

            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_q <= '0;
                    cnt_q <= staged_watchdog_pkg::CNT_RST;
                    stg_q <= staged_watchdog_pkg::STG_RST;
                    evt_q <= '0;
                end else begin
                    if (cfg_take) begin
                        cfg_q <= cfg_i[g];
                    end
                    evt_q.intr     <= hit &&
                        act == staged_watchdog_pkg::ACT_INTR;
                    evt_q.cpu_rst  <= hit &&
                        act == staged_watchdog_pkg::ACT_CPU_RST;
                    evt_q.core_rst <= (hit &&
                        act == staged_watchdog_pkg::ACT_CORE_RST);
                    evt_q.sys_rst  <= (IS_RTC && hit &&
                        act == staged_watchdog_pkg::ACT_SYS_RST) ||
                        (IS_RTC && boot_fire_q);
                    if (feed_i[g] || !running) begin
                        cnt_q <= staged_watchdog_pkg::CNT_RST;
                        stg_q <= staged_watchdog_pkg::STG_RST;
                    end else if (expire || skip) begin
                        cnt_q <= staged_watchdog_pkg::CNT_RST;
                        stg_q <= stg_q + 2'h1;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
            end
            assign evt_o[g]   = evt_q;
            assign stage_o[g] = stg_q;
            assign count_o[g] = cnt_q;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: staged_watchdog_pkg.sv */
// constants and types shared by the staged watchdog block
// What this block does
// - Three watchdogs run side by side: one main-system watchdog per timer group and one in the always-on domain.
// - Each watchdog has four stages, each with its own timeout and its own enable.
// - A main-system watchdog stage expiry raises an interrupt, a cpu reset or a core reset as configured.
// - An always-on watchdog stage expiry may also request a full system reset.
// - While write protection is on, configuration writes leave the configuration unchanged.
// - During flash boot the always-on watchdog and the timer group zero watchdog arm themselves.
// - If flash boot does not finish in the protection interval the whole main system is rebooted.
package staged_watchdog_pkg;
    localparam int unsigned NUM_WDT    = 3;
    localparam int unsigned NUM_STAGES = 4;
    localparam int unsigned CNT_W      = 32;
    localparam int unsigned IDX_TG0    = 0;
    localparam int unsigned IDX_TG1    = 1;
    localparam int unsigned IDX_RTC    = 2;
    // boot protection interval in microseconds and its cycle count
    localparam int unsigned BOOT_PROT_US = 100000;
    localparam int unsigned CLK_MHZ      = 100;
    localparam logic [CNT_W-1:0] BOOT_PROT_CYC =
        CNT_W'(BOOT_PROT_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [1:0]       STG_RST = 2'h0;

    typedef enum logic [2:0] {
        ACT_OFF, ACT_INTR, ACT_CPU_RST, ACT_CORE_RST, ACT_SYS_RST
    } wdt_action_t;

    typedef struct packed {
        logic                          en;
        logic [NUM_STAGES-1:0]         stage_en;
        wdt_action_t [NUM_STAGES-1:0]  action;
        logic [NUM_STAGES-1:0][CNT_W-1:0] timeout;
    } wdt_cfg_t;

    typedef struct packed {
        logic intr;
        logic cpu_rst;
        logic core_rst;
        logic sys_rst;
    } wdt_evt_t;
endpackage

/* File: staged_watchdog_chk.sv */
// assertions and covers for the staged watchdog block
`timescale 1ns/1ps
`default_nettype none
module staged_watchdog_chk #(
    parameter logic [31:0] BOOT_PROT_CYC = 32'h32
) (
    // clock, reset and inputs
    input wire logic                                clk_i,
    input wire logic                                nrst_i,
    input wire logic [2:0]                          cfg_we_i,
    input wire staged_watchdog_pkg::wdt_cfg_t [2:0] cfg_i,
    input wire logic [2:0]                          wprot_i,
    input wire logic [2:0]                          feed_i,
    input wire logic                                flash_boot_i,
    input wire logic                                boot_done_i,
    // outputs watched
    input wire staged_watchdog_pkg::wdt_evt_t [2:0] evt_o,
    input wire logic [2:0][1:0]                     stage_o,
    input wire logic [2:0][31:0]                    count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    rst_quiet_a: assert property (disable iff (1'b0)
        !nrst_i |-> evt_o == '0 && count_o == '0) else $error("reset leak");
    rel_quiet_a: assert property (disable iff (1'b0)
        $rose(nrst_i) |-> evt_o == '0 ##1 evt_o == '0) else $error("early evt");
    main_no_sys_a: assert property (!evt_o[0].sys_rst &&
        !evt_o[1].sys_rst) else $error("main watchdog system reset");
    one_act_a: assert property ($onehot0(evt_o[0]) &&
        $onehot0(evt_o[1]) && $onehot0(evt_o[2])) else $error("two actions");
    feed_main_a: assert property (feed_i[0] |=>
        count_o[0] == '0 && stage_o[0] == '0) else $error("feed main");
    feed_rtc_a: assert property (feed_i[2] |=>
        count_o[2] == '0 && stage_o[2] == '0) else $error("feed rtc");
    stage_step_a: assert property (evt_o[0].intr |->
        stage_o[0] != $past(stage_o[0])) else $error("stage stuck");
    cnt_zero_a: assert property (evt_o[2].intr |->
        count_o[2] == '0) else $error("count not restarted");
    cover property (evt_o[0].intr);
    cover property (evt_o[1].cpu_rst);
    cover property (evt_o[2].sys_rst);
endmodule
bind staged_watchdog_timer staged_watchdog_chk #(
    .BOOT_PROT_CYC(BOOT_PROT_CYC)) chk_u (.clk_i, .nrst_i, .cfg_we_i,
    .cfg_i, .wprot_i, .feed_i, .flash_boot_i, .boot_done_i, .evt_o,
    .stage_o, .count_o);
`default_nettype wire

/* File: staged_watchdog_timer_tb_top.sv */
// self-checking bench for the staged watchdog block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module staged_watchdog_timer_tb_top;
    logic clk_i = 1'b0, nrst_i = 1'b1, flash_boot_i = 1'b0, boot_done_i = 1'b0;
    logic [2:0] cfg_we_i = '0, wprot_i = '0, feed_i = '0;
    staged_watchdog_pkg::wdt_cfg_t [2:0] cfg_i = '0;
    staged_watchdog_pkg::wdt_evt_t [2:0] evt_o;
    logic [2:0][1:0] stage_o;
    logic [2:0][31:0] count_o;
    int n_errors = 0, comparisons = 0, n;
    always #5 clk_i = ~clk_i;
    staged_watchdog_timer #(.BOOT_PROT_CYC(32'h32)) dut_u (.clk_i, .nrst_i,
        .cfg_we_i, .cfg_i, .wprot_i, .feed_i, .flash_boot_i, .boot_done_i,
        .evt_o, .stage_o, .count_o);
    task automatic conclude();
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic do_reset();
        nrst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask
    // one enabled stage with the given action and timeout
    task automatic wr(input int g, input int a, input logic [31:0] t);
        @(negedge clk_i);
        cfg_i[g] = '0;
        cfg_i[g].en = 1'b1;
        cfg_i[g].stage_en = 4'h1;
        cfg_i[g].action[0] = staged_watchdog_pkg::wdt_action_t'(a);
        cfg_i[g].timeout[0] = t;
        cfg_we_i[g] = 1'b1;
        @(negedge clk_i) cfg_we_i[g] = 1'b0;
    endtask
    task automatic wait_evt(input int g, input int lim);
        n = 0;
        while (evt_o[g] === 4'h0 && n < lim) begin
            @(posedge clk_i);
            #1 n++;
        end
        if (n >= lim) begin n_errors++; conclude(); end
    endtask
    task automatic quiet(input int c);
        logic [3:0] acc = 4'h0;
        repeat (c) begin
            @(posedge clk_i);
            #1 acc |= evt_o[0] | evt_o[1] | evt_o[2];
        end
        @(negedge clk_i);
        `CHK(acc, 4'h0)
    endtask
    task automatic t_walk();
        wr(0, 1, 32'h2);
        wait_evt(0, 20);
        `CHK(n, 3)
        `CHK(evt_o[0], 4'h8)
        `CHK(stage_o[0], 2'h1)
        wr(0, 0, 32'h0);
    endtask
    task automatic t_act();
        for (int g = 1; g < 3; g++) begin
            for (int k = 1; k < g + 3; k++) begin
                wr(g, 0, 32'h0);
                repeat (2) @(negedge clk_i);
                wr(g, k, 32'h1);
                wait_evt(g, 20);
                `CHK(evt_o[g], 4'h8 >> (k - 1))
            end
            wr(g, 0, 32'h0);
        end
    endtask
    task automatic t_prot_feed();
        wprot_i[1] = 1'b1;
        wr(1, 1, 32'h0);
        quiet(30);
        wprot_i[1] = 1'b0;
        feed_i = 3'h5;
        wr(0, 1, 32'h3);
        wr(2, 1, 32'h3);
        quiet(30);
        @(negedge clk_i) feed_i = 3'h0;
        wait_evt(0, 20);
        `CHK(evt_o[0], 4'h8)
    endtask
    initial begin
        #1 do_reset();
        t_walk();
        t_act();
        t_prot_feed();
        do_reset();
        flash_boot_i = 1'b1;
        wait_evt(2, 200);
        `CHK(evt_o[2], 4'h1)
        do_reset();
        boot_done_i = 1'b1;
        quiet(120);
        conclude();
    end
endmodule
`default_nettype wire
